/* File: crss_pkg.sv */
// crss_pkg: constants, timing counts and state types shared by both ends of the
// codec reset and startup sequencer.
// assumes a single 250 MHz clock shared by host end and device end.
package crss_pkg;
	localparam int TIMER_W = 20;
	typedef logic [TIMER_W-1:0] crss_timer_t;

	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_RST_HOLD_PS = 10000;
	localparam int T_INIT_PS = 1000000000;
	localparam int T_LOCKOUT_PS = 1000000000;
	localparam int T_PLL_PS = 1000000000;
	localparam int T_CAP_PS = 2000000000;
	localparam int T_REF_PS = 100000000;

	// longest time rounds down, least times round up
	localparam crss_timer_t INIT_CYC = crss_timer_t'(T_INIT_PS / CLK_PERIOD_PS);
	localparam crss_timer_t RST_HOLD_CYC =
		crss_timer_t'((T_RST_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam crss_timer_t LOCKOUT_CYC =
		crss_timer_t'((T_LOCKOUT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam crss_timer_t PLL_CYC =
		crss_timer_t'((T_PLL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam crss_timer_t CAP_CYC =
		crss_timer_t'((T_CAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam crss_timer_t REF_CYC =
		crss_timer_t'((T_REF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	localparam logic CM_SEL_RST = 1'h0;
	localparam logic CM_SEL_0V75 = 1'h1;
	localparam logic REC_FIFO_EN_RST = 1'h0;
	localparam logic PLAY_FIFO_EN_RST = 1'h0;
	localparam logic [1:0] FRAME_SYNC_RST = 2'h0;
	localparam logic [1:0] FRAME_SYNC_OFF = 2'h3;
	localparam logic HP_PREP_RST = 1'h0;

	localparam int SAMPLE_W = 16;
	localparam int FIFO_STAGES = 4;

	typedef enum logic [1:0] {C_INIT = 2'b01, C_READY = 2'b10} crss_core_st_t;
	typedef enum logic [2:0] {R_OFF = 3'b001, R_START = 3'b010, R_ON = 3'b100} crss_ref_st_t;
	typedef enum logic [3:0] {
		P_OFF = 4'b0001, P_QUEUED = 4'b0010, P_LOCK = 4'b0100, P_ON = 4'b1000
	} crss_pll_st_t;
	typedef enum logic [4:0] {
		H_SUPPLY = 5'b00001, H_HOLD = 5'b00010, H_LOCK = 5'b00100,
		H_CFG = 5'b01000, H_RUN = 5'b10000
	} crss_host_st_t;
endpackage : crss_pkg

/* File: crss_if.sv */
// crss_if: link between the host controller end and the codec device end.
// assumes both ends run on the same clock; the reset pin is the only asynchronous wire.
interface crss_if;
	logic rst_pin_b;
	logic soft_rst;
	logic cfg_wr;
	logic cm_sel;
	logic rec_fifo_en;
	logic play_fifo_en;
	logic [1:0] frame_sync;
	logic hp_prep;
	logic ref_req;
	logic adc_req;
	logic route_req;
	logic hp_req;
	logic pll_req;
	logic init_busy;
	logic ref_ready;
	logic clk_ready;

	modport dev (
		input rst_pin_b, soft_rst, cfg_wr, cm_sel, rec_fifo_en, play_fifo_en, frame_sync,
		input hp_prep, ref_req, adc_req, route_req, hp_req, pll_req,
		output init_busy, ref_ready, clk_ready
	);
	modport host (
		output rst_pin_b, soft_rst, cfg_wr, cm_sel, rec_fifo_en, play_fifo_en, frame_sync,
		output hp_prep, ref_req, adc_req, route_req, hp_req, pll_req,
		input init_busy, ref_ready, clk_ready
	);
endinterface : crss_if

/* File: crss_timer.sv */
// crss_timer: one-shot down counter, done pulses i_count cycles after the load edge.
// assumes i_count is at least one; a load while running restarts it.
module crss_timer #(
	parameter int W = 20
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_busy,
	output logic o_done
);
	import crss_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
		logic done;
	} crss_tmr_st_t;

	crss_tmr_st_t st_reg;
	crss_tmr_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (i_load) begin
			st_next.cnt = i_count;
			st_next.busy = 1'b1;
		end else if (st_reg.busy) begin
			st_next.cnt = st_reg.cnt - W'(1);
			if (st_reg.cnt == W'(1)) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_busy = st_reg.busy;
	assign o_done = st_reg.done;
endmodule : crss_timer

/* File: crss_device.sv */
// crss_device: codec digital core reset, default load, sleep, reference and pll
// startup sequencing, plus the record and playback fifo delay stages.
// assumes the host drives the link on i_clk; only the reset pin is asynchronous.
// Operation
// - host holds reset pin low at least 10 ns
// - soft reset bit resets like the pin
// - every reset reloads all default register values
// - after reset sleep, control port stays alive
// - register initialisation finishes within 1 ms
// - host writes nothing for 1 ms after reset
// - host avoids coefficients and power-up during init
// - host holds reset low during supply ramp
// - shared bus traffic only after supplies, reset
// - any analog request also powers the reference
// - requests queue until reference startup completes
// - host waits 2 ms before adc routing
// - codec clocks withheld 1 ms after pll up
// - cm select bit picks 0.75 or 0.9 V
// - record fifo off after reset, bit enables
// - playback fifo off after reset, bit enables
// - frame sync default aligned, 11 disables it
// - host sets headphone prep before headphone up
// - enabled fifos add group delay to path
module crss_device #(
	parameter crss_pkg::crss_timer_t INIT_CYC = crss_pkg::INIT_CYC,
	parameter crss_pkg::crss_timer_t REF_CYC = crss_pkg::REF_CYC,
	parameter crss_pkg::crss_timer_t PLL_CYC = crss_pkg::PLL_CYC,
	parameter int N = crss_pkg::FIFO_STAGES,
	parameter int DW = crss_pkg::SAMPLE_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	crss_if.dev bus,
	input wire logic i_rec_valid,
	input wire logic [DW-1:0] i_rec_data,
	input wire logic i_play_valid,
	input wire logic [DW-1:0] i_play_data,
	output logic o_rec_valid,
	output logic [DW-1:0] o_rec_data,
	output logic o_play_valid,
	output logic [DW-1:0] o_play_data,
	output logic o_init_busy,
	output logic o_sleep,
	output logic o_ref_en,
	output logic o_adc_en,
	output logic o_adc_route_en,
	output logic o_hp_en,
	output logic o_pll_en,
	output logic o_codec_clk_en,
	output logic o_cm_sel,
	output logic o_rec_fifo_en,
	output logic o_play_fifo_en,
	output logic [1:0] o_frame_sync,
	output logic o_hp_prep
);
	import crss_pkg::*;

	typedef struct packed {
		crss_core_st_t core;
		logic init_started;
		crss_ref_st_t refs;
		crss_pll_st_t pll;
		logic cm_sel;
		logic rec_fifo_en;
		logic play_fifo_en;
		logic [1:0] frame_sync;
		logic hp_prep;
		logic adc_en;
		logic route_en;
		logic hp_en;
		logic [N-1:0] rec_v;
		logic [N-1:0][DW-1:0] rec_d;
		logic [N-1:0] play_v;
		logic [N-1:0][DW-1:0] play_d;
		logic rec_ov;
		logic [DW-1:0] rec_od;
		logic play_ov;
		logic [DW-1:0] play_od;
	} crss_dev_st_t;

	function automatic crss_dev_st_t dev_defaults();
		crss_dev_st_t d;
		d = '0;
		d.core = C_INIT;
		d.refs = R_OFF;
		d.pll = P_OFF;
		d.cm_sel = CM_SEL_RST;
		d.rec_fifo_en = REC_FIFO_EN_RST;
		d.play_fifo_en = PLAY_FIFO_EN_RST;
		d.frame_sync = FRAME_SYNC_RST;
		d.hp_prep = HP_PREP_RST;
		return d;
	endfunction : dev_defaults

	localparam crss_dev_st_t ST_RST = dev_defaults();

	function automatic logic [N-1:0] shift_v(input logic [N-1:0] p, input logic v);
		return {p[N-2:0], v};
	endfunction : shift_v

	function automatic logic [N-1:0][DW-1:0] shift_d(
		input logic [N-1:0][DW-1:0] p,
		input logic [DW-1:0] d
	);
		return {p[N-2:0], d};
	endfunction : shift_d

	logic rst_meta_b;
	logic rst_sync_b;
	logic pin_or_por_b;
	crss_dev_st_t st_reg;
	crss_dev_st_t st_next;
	logic init_load;
	logic init_done;
	logic ref_load;
	logic ref_done;
	logic pll_load;
	logic pll_done;
	logic ref_want;

	// pin pulses shorter than a clock period still reach the core through the async clear
	assign pin_or_por_b = i_rst_b & bus.rst_pin_b;

	always_ff @(posedge i_clk or negedge pin_or_por_b) begin
		if (!pin_or_por_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	crss_timer #(.W(TIMER_W)) u_init_tmr (
		.i_clk(i_clk),
		.i_rst_b(rst_sync_b),
		.i_load(init_load),
		// sync, load and exit edges count against the window after the pin
		.i_count(INIT_CYC - crss_timer_t'(3)),
		.o_busy(),
		.o_done(init_done)
	);

	crss_timer #(.W(TIMER_W)) u_ref_tmr (
		.i_clk(i_clk),
		.i_rst_b(rst_sync_b),
		.i_load(ref_load),
		.i_count(REF_CYC),
		.o_busy(),
		.o_done(ref_done)
	);

	crss_timer #(.W(TIMER_W)) u_pll_tmr (
		.i_clk(i_clk),
		.i_rst_b(rst_sync_b),
		.i_load(pll_load),
		.i_count(PLL_CYC),
		.o_busy(),
		.o_done(pll_done)
	);

	assign ref_want = bus.ref_req | bus.adc_req | bus.hp_req | bus.pll_req;

	always_comb begin
		st_next = st_reg;
		init_load = 1'b0;
		ref_load = 1'b0;
		pll_load = 1'b0;
		// fifo stages always shift so a bypass switch never strands a sample
		st_next.rec_v = shift_v(st_reg.rec_v, i_rec_valid);
		st_next.rec_d = shift_d(st_reg.rec_d, i_rec_data);
		st_next.play_v = shift_v(st_reg.play_v, i_play_valid);
		st_next.play_d = shift_d(st_reg.play_d, i_play_data);
		st_next.rec_ov = st_reg.rec_fifo_en ? st_reg.rec_v[N-1] : i_rec_valid;
		st_next.rec_od = st_reg.rec_fifo_en ? st_reg.rec_d[N-1] : i_rec_data;
		st_next.play_ov = st_reg.play_fifo_en ? st_reg.play_v[N-1] : i_play_valid;
		st_next.play_od = st_reg.play_fifo_en ? st_reg.play_d[N-1] : i_play_data;
		case (st_reg.core)
			C_INIT: begin
				// requests and writes are ignored until defaults are loaded
				if (!st_reg.init_started) begin
					init_load = 1'b1;
					st_next.init_started = 1'b1;
				end else if (init_done) begin
					st_next.core = C_READY;
				end
			end
			C_READY: begin
				if (bus.cfg_wr) begin
					st_next.cm_sel = bus.cm_sel;
					st_next.rec_fifo_en = bus.rec_fifo_en;
					st_next.play_fifo_en = bus.play_fifo_en;
					st_next.frame_sync = bus.frame_sync;
					st_next.hp_prep = bus.hp_prep;
				end
				case (st_reg.refs)
					R_OFF: begin
						if (ref_want) begin
							st_next.refs = R_START;
							ref_load = 1'b1;
						end
					end
					R_START: begin
						if (!ref_want) begin
							st_next.refs = R_OFF;
						end else if (ref_done) begin
							st_next.refs = R_ON;
						end
					end
					R_ON: begin
						if (!ref_want) begin
							st_next.refs = R_OFF;
						end
					end
					default: st_next.refs = R_OFF;
				endcase
				case (st_reg.pll)
					P_OFF: begin
						if (bus.pll_req) begin
							st_next.pll = P_QUEUED;
						end
					end
					P_QUEUED: begin
						if (!bus.pll_req) begin
							st_next.pll = P_OFF;
						end else if (st_next.refs == R_ON) begin
							st_next.pll = P_LOCK;
							pll_load = 1'b1;
						end
					end
					P_LOCK: begin
						if (!bus.pll_req || st_next.refs != R_ON) begin
							st_next.pll = P_OFF;
						end else if (pll_done) begin
							st_next.pll = P_ON;
						end
					end
					P_ON: begin
						if (!bus.pll_req || st_next.refs != R_ON) begin
							st_next.pll = P_OFF;
						end
					end
					default: st_next.pll = P_OFF;
				endcase
				// analog blocks held back until the reference is up
				st_next.adc_en = (st_next.refs == R_ON) && bus.adc_req;
				st_next.hp_en = (st_next.refs == R_ON) && bus.hp_req;
				st_next.route_en = st_next.adc_en && bus.route_req;
			end
			default: st_next = ST_RST;
		endcase
		if (bus.soft_rst) begin
			st_next = ST_RST;
		end
	end

	always_ff @(posedge i_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rec_valid = st_reg.rec_ov;
	assign o_rec_data = st_reg.rec_od;
	assign o_play_valid = st_reg.play_ov;
	assign o_play_data = st_reg.play_od;
	assign o_init_busy = st_reg.core == C_INIT;
	assign o_sleep = (st_reg.core == C_INIT) || (st_reg.refs == R_OFF);
	assign o_ref_en = st_reg.refs != R_OFF;
	assign o_adc_en = st_reg.adc_en;
	assign o_adc_route_en = st_reg.route_en;
	assign o_hp_en = st_reg.hp_en;
	assign o_pll_en = (st_reg.pll == P_LOCK) || (st_reg.pll == P_ON);
	assign o_codec_clk_en = st_reg.pll == P_ON;
	assign o_cm_sel = st_reg.cm_sel;
	assign o_rec_fifo_en = st_reg.rec_fifo_en;
	assign o_play_fifo_en = st_reg.play_fifo_en;
	assign o_frame_sync = st_reg.frame_sync;
	assign o_hp_prep = st_reg.hp_prep;
	assign bus.init_busy = st_reg.core == C_INIT;
	assign bus.ref_ready = st_reg.refs == R_ON;
	assign bus.clk_ready = st_reg.pll == P_ON;
endmodule : crss_device

/* File: crss_host.sv */
// crss_host: host controller end; applies reset, keeps lockout, writes the
// configuration and forwards power requests in a safe order.
// assumes the device end shares i_clk; i_supplies_good comes from a supply monitor pin.
module crss_host #(
	parameter crss_pkg::crss_timer_t LOCKOUT_CYC = crss_pkg::LOCKOUT_CYC,
	parameter crss_pkg::crss_timer_t CAP_CYC = crss_pkg::CAP_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	crss_if.host bus,
	input wire logic i_supplies_good,
	input wire logic i_soft_reset,
	input wire logic i_cfg_apply,
	input wire logic i_avdd_low,
	input wire logic i_cm_0v75,
	input wire logic i_rec_fifo_en,
	input wire logic i_play_fifo_en,
	input wire logic i_prb_playback,
	input wire logic i_ref_on,
	input wire logic i_adc_on,
	input wire logic i_adc_route,
	input wire logic i_hp_on,
	input wire logic i_pll_on,
	output logic o_ready,
	output logic o_clk_ready
);
	import crss_pkg::*;

	typedef struct packed {
		crss_host_st_t state;
		logic sup_meta;
		logic sup_sync;
		logic rst_pin_b;
		logic soft_rst;
		logic cfg_wr;
		logic cm_sel;
		logic rec_fifo_en;
		logic play_fifo_en;
		logic [1:0] frame_sync;
		logic hp_prep;
		logic ref_req;
		logic adc_req;
		logic adc_live;
		logic route_ok;
		logic route_req;
		logic hp_req;
		logic pll_req;
	} crss_host_st_all_t;

	crss_host_st_all_t st_reg;
	crss_host_st_all_t st_next;
	logic seq_load;
	crss_timer_t seq_count;
	logic seq_done;
	logic cap_load;
	logic cap_done;

	crss_timer #(.W(TIMER_W)) u_seq_tmr (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_load(seq_load),
		.i_count(seq_count),
		.o_busy(),
		.o_done(seq_done)
	);

	crss_timer #(.W(TIMER_W)) u_cap_tmr (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_load(cap_load),
		.i_count(CAP_CYC),
		.o_busy(),
		.o_done(cap_done)
	);

	always_comb begin
		st_next = st_reg;
		seq_load = 1'b0;
		seq_count = LOCKOUT_CYC;
		cap_load = 1'b0;
		st_next.sup_meta = i_supplies_good;
		st_next.sup_sync = st_reg.sup_meta;
		st_next.soft_rst = 1'b0;
		st_next.cfg_wr = 1'b0;
		case (st_reg.state)
			H_SUPPLY: begin
				st_next.rst_pin_b = 1'b0;
				if (st_reg.sup_sync) begin
					st_next.state = H_HOLD;
					seq_load = 1'b1;
					seq_count = RST_HOLD_CYC;
				end
			end
			H_HOLD: begin
				if (seq_done) begin
					st_next.rst_pin_b = 1'b1;
					st_next.state = H_LOCK;
					seq_load = 1'b1;
				end
			end
			H_LOCK: begin
				if (seq_done || (!seq_load && !bus.init_busy && st_reg.cfg_wr)) begin
					st_next.state = H_CFG;
				end
			end
			H_CFG: begin
				if (!bus.init_busy) begin
					st_next.cfg_wr = 1'b1;
					st_next.state = H_RUN;
				end
			end
			H_RUN: begin
				if (i_soft_reset) begin
					st_next = st_reg;
					st_next.sup_meta = i_supplies_good;
					st_next.sup_sync = st_reg.sup_meta;
					st_next.cfg_wr = 1'b0;
					st_next.soft_rst = 1'b1;
					{st_next.ref_req, st_next.adc_req, st_next.hp_req, st_next.pll_req} = 4'h0;
					{st_next.adc_live, st_next.route_ok, st_next.route_req} = 3'h0;
					st_next.hp_prep = HP_PREP_RST;
					st_next.state = H_LOCK;
					seq_load = 1'b1;
				end else begin
					if (i_cfg_apply || (i_hp_on && !st_reg.hp_prep)) begin
						st_next.cfg_wr = 1'b1;
						st_next.hp_prep = i_hp_on;
					end
					st_next.ref_req = i_ref_on;
					st_next.adc_req = i_adc_on;
					st_next.pll_req = i_pll_on;
					st_next.hp_req = i_hp_on && st_reg.hp_prep && !st_next.cfg_wr;
					st_next.adc_live = st_reg.adc_req && bus.ref_ready;
					if (st_next.adc_live && !st_reg.adc_live) begin
						cap_load = 1'b1;
					end
					if (!st_next.adc_live) begin
						st_next.route_ok = 1'b0;
					end else if (cap_done) begin
						st_next.route_ok = 1'b1;
					end
					st_next.route_req = i_adc_route && st_reg.route_ok;
				end
			end
			default: st_next.state = H_SUPPLY;
		endcase
		if (st_next.cfg_wr) begin
			st_next.cm_sel = (i_avdd_low | i_cm_0v75) ? CM_SEL_0V75 : CM_SEL_RST;
			st_next.rec_fifo_en = i_rec_fifo_en;
			st_next.play_fifo_en = i_play_fifo_en;
			st_next.frame_sync = i_prb_playback ? FRAME_SYNC_OFF : FRAME_SYNC_RST;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '{state: H_SUPPLY, frame_sync: FRAME_SYNC_RST, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus.rst_pin_b = st_reg.rst_pin_b;
	assign bus.soft_rst = st_reg.soft_rst;
	assign bus.cfg_wr = st_reg.cfg_wr;
	assign bus.cm_sel = st_reg.cm_sel;
	assign bus.rec_fifo_en = st_reg.rec_fifo_en;
	assign bus.play_fifo_en = st_reg.play_fifo_en;
	assign bus.frame_sync = st_reg.frame_sync;
	assign bus.hp_prep = st_reg.hp_prep;
	assign bus.ref_req = st_reg.ref_req;
	assign bus.adc_req = st_reg.adc_req;
	assign bus.route_req = st_reg.route_req;
	assign bus.hp_req = st_reg.hp_req;
	assign bus.pll_req = st_reg.pll_req;
	assign o_ready = st_reg.state == H_RUN;
	assign o_clk_ready = bus.clk_ready;
endmodule : crss_host

/* File: crss_props.sv */
// crss_props: assertions on the link between the host end and the device end.
// assumes one clock; i_rst_b is the power-on reset shared by both ends.
module crss_props #(
	parameter int INIT_CYC = 20,
	parameter int PLL_CYC = 30,
	parameter int REF_CYC = 20,
	parameter int CAP_CYC = 25
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic rst_pin_b,
	input wire logic soft_rst,
	input wire logic cfg_wr,
	input wire logic hp_prep,
	input wire logic ref_req,
	input wire logic adc_req,
	input wire logic route_req,
	input wire logic hp_req,
	input wire logic pll_req,
	input wire logic init_busy,
	input wire logic ref_ready,
	input wire logic clk_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int REF_MAX = REF_CYC + 4;
	int busy_cnt;
	int lock_cnt;
	int cap_cnt;
	int quiet_cnt;
	logic any_req;
	assign any_req = ref_req | adc_req | hp_req | pll_req;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// run-length counters keep long waits out of repetition operators
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy_cnt <= 0;
			lock_cnt <= 0;
			cap_cnt <= 0;
			quiet_cnt <= 0;
		end else begin
			busy_cnt <= (init_busy && rst_pin_b) ? busy_cnt + 1 : 0;
			lock_cnt <= (pll_req && ref_ready && !clk_ready) ? lock_cnt + 1 : 0;
			cap_cnt <= (adc_req && ref_ready) ? cap_cnt + 1 : 0;
			quiet_cnt <= (!rst_pin_b || soft_rst) ? 0 : quiet_cnt + 1;
		end
	end
	property p_rst_hold; $rose(rst_pin_b) |-> !$past(rst_pin_b, 2) && !$past(rst_pin_b, 3); endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset pin pulse too short");
	property p_soft_busy; soft_rst && rst_pin_b |=> init_busy; endproperty
	a_soft_busy: assert property (p_soft_busy) else $error("soft reset not taken");
	property p_init_len; $fell(init_busy) |-> busy_cnt >= INIT_CYC - 1; endproperty
	a_init_len: assert property (p_init_len) else $error("init ended early");
	property p_init_max; busy_cnt <= INIT_CYC + 3; endproperty
	a_init_max: assert property (p_init_max) else $error("init too long");
	property p_lockout; cfg_wr |-> !init_busy && quiet_cnt >= INIT_CYC; endproperty
	a_lockout: assert property (p_lockout) else $error("write inside lockout");
	property p_no_req; init_busy && $past(init_busy) |-> !any_req; endproperty
	a_no_req: assert property (p_no_req) else $error("power request during init");
	property p_ref_up; $rose(any_req) && !init_busy |-> ##[1:REF_MAX] (ref_ready || !any_req); endproperty
	a_ref_up: assert property (p_ref_up) else $error("reference did not start");
	property p_queue; clk_ready |-> ref_ready; endproperty
	a_queue: assert property (p_queue) else $error("pll clocks before reference");
	property p_pll_wait; $rose(clk_ready) |-> lock_cnt >= PLL_CYC - 1; endproperty
	a_pll_wait: assert property (p_pll_wait) else $error("codec clocks too early");
	property p_pll_max; lock_cnt <= PLL_CYC + 2; endproperty
	a_pll_max: assert property (p_pll_max) else $error("codec clocks too late");
	property p_route; $rose(route_req) |-> cap_cnt >= CAP_CYC - 1; endproperty
	a_route: assert property (p_route) else $error("routing before charge time");
	property p_hp_prep; $rose(hp_req) |-> hp_prep; endproperty
	a_hp_prep: assert property (p_hp_prep) else $error("headphone without prep");
endmodule : crss_props

/* File: crss_test.sv */
// crss_test: host end and device end joined by crss_if, driven from the host user side.
// assumes short init, lock and charge counts; expectations derive from them.
module crss_test;
	timeunit 1ns;
	timeprecision 100ps;
	import crss_pkg::*;
	localparam int INIT_N = 20;
	localparam int REF_N = 20;
	localparam int PLL_N = 30;
	localparam int LOCK_N = 30;
	localparam int CAP_N = 25;
	logic clk, rst_b, supplies_good, soft_reset, cfg_apply, avdd_low, cm_0v75, rec_en, play_en, predefined_processing_mode;
	logic ref_on, adc_on, adc_route, hp_on, pll_on, rec_valid, play_valid, h_ready, h_clk_ready;
	logic [SAMPLE_W-1:0] rec_data, play_data, d_rec_data, d_play_data;
	logic d_rec_valid, d_play_valid, d_init_busy, d_sleep, d_ref_en, d_adc_en, d_route_en, d_hp_en;
	logic d_pll_en, d_codec_clk_en, d_cm_sel, d_rec_fifo_en, d_play_fifo_en, d_hp_prep;
	logic [1:0] d_frame_sync;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	crss_if u_crss_if ();
	crss_host #(.LOCKOUT_CYC(crss_timer_t'(LOCK_N)), .CAP_CYC(crss_timer_t'(CAP_N))) u_crss_host (
		.i_clk(clk), .i_rst_b(rst_b), .bus(u_crss_if), .i_supplies_good(supplies_good),
		.i_soft_reset(soft_reset), .i_cfg_apply(cfg_apply), .i_avdd_low(avdd_low),
		.i_cm_0v75(cm_0v75), .i_rec_fifo_en(rec_en), .i_play_fifo_en(play_en), .i_prb_playback(predefined_processing_mode),
		.i_ref_on(ref_on), .i_adc_on(adc_on), .i_adc_route(adc_route), .i_hp_on(hp_on),
		.i_pll_on(pll_on), .o_ready(h_ready), .o_clk_ready(h_clk_ready));
	crss_device #(.INIT_CYC(crss_timer_t'(INIT_N)), .REF_CYC(crss_timer_t'(REF_N)),
		.PLL_CYC(crss_timer_t'(PLL_N))) u_crss_device (
		.i_clk(clk), .i_rst_b(rst_b), .bus(u_crss_if), .i_rec_valid(rec_valid),
		.i_rec_data(rec_data), .i_play_valid(play_valid), .i_play_data(play_data),
		.o_rec_valid(d_rec_valid), .o_rec_data(d_rec_data), .o_play_valid(d_play_valid),
		.o_play_data(d_play_data), .o_init_busy(d_init_busy), .o_sleep(d_sleep), .o_ref_en(d_ref_en),
		.o_adc_en(d_adc_en), .o_adc_route_en(d_route_en), .o_hp_en(d_hp_en), .o_pll_en(d_pll_en),
		.o_codec_clk_en(d_codec_clk_en), .o_cm_sel(d_cm_sel), .o_rec_fifo_en(d_rec_fifo_en),
		.o_play_fifo_en(d_play_fifo_en), .o_frame_sync(d_frame_sync), .o_hp_prep(d_hp_prep));
	crss_props #(.INIT_CYC(INIT_N), .PLL_CYC(PLL_N), .REF_CYC(REF_N), .CAP_CYC(CAP_N)) u_crss_props (
		.i_clk(clk), .i_rst_b(rst_b), .rst_pin_b(u_crss_if.rst_pin_b), .soft_rst(u_crss_if.soft_rst),
		.cfg_wr(u_crss_if.cfg_wr), .hp_prep(u_crss_if.hp_prep), .ref_req(u_crss_if.ref_req),
		.adc_req(u_crss_if.adc_req), .route_req(u_crss_if.route_req), .hp_req(u_crss_if.hp_req),
		.pll_req(u_crss_if.pll_req), .init_busy(u_crss_if.init_busy),
		.ref_ready(u_crss_if.ref_ready), .clk_ready(u_crss_if.clk_ready));
	always #2 clk = ~clk;
	task summarize();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("mismatch at %0t: timeout", $time);
			summarize();
		end
	end
	task chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'h1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk
	function logic sig(input int s);
		case (s)
			0: return h_ready;
			1: return u_crss_if.init_busy;
			2: return !u_crss_if.init_busy;
			3: return u_crss_if.ref_ready;
			4: return d_ref_en;
			5: return d_hp_en;
			default: return u_crss_if.rst_pin_b;
		endcase
	endfunction : sig
	task wait_on(input int s, input int lim, output int n);
		n = 0;
		while (sig(s) !== 1'h1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(sig(s) === 1'h1, "wait limit");
	endtask : wait_on
	task chk_sleep();
		chk(d_cm_sel === CM_SEL_RST && d_frame_sync === FRAME_SYNC_RST, "cfg defaults");
		chk(d_rec_fifo_en === REC_FIFO_EN_RST && d_play_fifo_en === PLAY_FIFO_EN_RST, "fifo on");
		chk(d_ref_en === 1'h0 && d_hp_en === 1'h0 && d_hp_prep === HP_PREP_RST, "not asleep");
		chk(d_pll_en === 1'h0 && d_adc_en === 1'h0 && d_sleep === 1'h1, "not asleep");
	endtask : chk_sleep
	task bring_up(input logic hw);
		int n;
		wait_on(6, 60, n);
		wait_on(1, 8, n);
		chk(n == (hw ? 0 : 1), "busy start");
		chk_sleep();
		wait_on(2, INIT_N + 10, n);
		chk(n >= INIT_N - 1 && n <= INIT_N + 3, "init length");
		wait_on(0, LOCK_N + 20, n);
	endtask : bring_up
	task apply_cfg(input logic al, input logic cm, input logic fe, input logic pb);
		@(posedge clk);
		avdd_low <= al;
		cm_0v75 <= cm;
		rec_en <= fe;
		play_en <= fe;
		predefined_processing_mode <= pb;
		cfg_apply <= 1'h1;
		@(posedge clk);
		cfg_apply <= 1'h0;
		repeat (8) @(posedge clk);
		#1;
	endtask : apply_cfg
	task lat(input int exp);
		int nr;
		int np;
		nr = 0;
		np = 0;
		@(posedge clk);
		rec_valid <= 1'h1;
		rec_data <= 16'h1234;
		play_valid <= 1'h1;
		play_data <= 16'hBEEF;
		for (int i = 1; i <= 8; i++) begin
			@(posedge clk);
			rec_valid <= 1'h0;
			play_valid <= 1'h0;
			#1;
			if (nr == 0 && d_rec_valid === 1'h1 && d_rec_data === 16'h1234) nr = i;
			if (np == 0 && d_play_valid === 1'h1 && d_play_data === 16'hBEEF) np = i;
		end
		chk(nr == exp && np == exp, "sample latency");
	endtask : lat
	task t_cfg();
		for (int k = 0; k < 3; k++) begin
			apply_cfg(k == 0, k == 1, k == 2, k == 2);
			chk(d_cm_sel === ((k < 2) ? CM_SEL_0V75 : ~CM_SEL_0V75), "cm select");
			chk(d_rec_fifo_en === (k == 2) && d_play_fifo_en === (k == 2), "fifo enable");
			chk(d_frame_sync === ((k == 2) ? FRAME_SYNC_OFF : FRAME_SYNC_RST), "frame sync");
		end
		lat(FIFO_STAGES + 1);
		apply_cfg(1'h0, 1'h0, 1'h0, 1'h0);
		lat(1);
	endtask : t_cfg
	task t_power();
		int n;
		int tc;
		int tr;
		@(posedge clk);
		ref_on <= 1'h1;
		wait_on(3, REF_N + 10, n);
		chk(d_ref_en === 1'h1 && d_pll_en === 1'h0 && d_adc_en === 1'h0, "reference alone");
		@(posedge clk);
		ref_on <= 1'h0;
		repeat (5) @(posedge clk);
		pll_on <= 1'h1;
		adc_on <= 1'h1;
		adc_route <= 1'h1;
		wait_on(4, 10, n);
		chk(d_codec_clk_en === 1'h0 && d_adc_en === 1'h0, "not queued");
		wait_on(3, REF_N + 5, n);
		tc = 0;
		tr = 0;
		for (int i = 1; i <= 80; i++) begin
			@(posedge clk);
			#1;
			if (tc == 0 && d_codec_clk_en === 1'h1) tc = i;
			if (tr == 0 && d_route_en === 1'h1) tr = i;
		end
		chk(d_adc_en === 1'h1, "adc not started");
		chk(tc >= PLL_N - 1 && tc <= PLL_N + 1 && h_clk_ready === 1'h1, "pll delay");
		chk(tr >= CAP_N - 1, "route wait");
		@(posedge clk);
		hp_on <= 1'h1;
		wait_on(5, 20, n);
		chk(d_hp_prep === 1'h1, "prep missing");
		@(posedge clk);
		{pll_on, adc_on, adc_route, hp_on} <= 4'h0;
		repeat (5) @(posedge clk);
		#1;
		chk(d_ref_en === 1'h0 && d_sleep === 1'h1, "reference left on");
	endtask : t_power
	task t_soft();
		int n;
		apply_cfg(1'h1, 1'h0, 1'h1, 1'h1);
		@(posedge clk);
		ref_on <= 1'h1;
		wait_on(4, 10, n);
		@(posedge clk);
		soft_reset <= 1'h1;
		@(posedge clk);
		soft_reset <= 1'h0;
		ref_on <= 1'h0;
		bring_up(1'h0);
	endtask : t_soft
	task t_hw();
		int n;
		@(posedge clk);
		ref_on <= 1'h1;
		wait_on(4, 40, n);
		// a synchronous clear would only show at the next edge
		@(posedge clk);
		rst_b <= 1'h0;
		ref_on <= 1'h0;
		#1;
		chk(d_ref_en === 1'h0 && d_init_busy === 1'h1, "async reset");
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		bring_up(1'h1);
	endtask : t_hw
	initial begin
		clk = 1'h0;
		rst_b = 1'h0;
		{supplies_good, soft_reset, cfg_apply, avdd_low, cm_0v75, rec_en, play_en, predefined_processing_mode} = 8'h00;
		{ref_on, adc_on, adc_route, hp_on, pll_on, rec_valid, play_valid} = 7'h00;
		rec_data = 16'h0000;
		play_data = 16'h0000;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		#1;
		chk(u_crss_if.rst_pin_b === 1'h0, "pin released before supplies");
		@(posedge clk);
		supplies_good <= 1'h1;
		bring_up(1'h1);
		t_cfg();
		t_power();
		t_soft();
		t_hw();
		summarize();
	end
endmodule : crss_test
